// File: rtl/hmc_cfg.svh
`ifndef HMC_CFG_SVH
`define HMC_CFG_SVH
`define HMC_CTRL_ADDR 16'h6040
`define HMC_CW_SWITCH_ON 0
`define HMC_CW_EN_VOLT 1
`define HMC_CW_QSTOP 2
`define HMC_CW_EN_OP 3
`define HMC_CW_START 4
`define HMC_CW_FAULT_RST 7
`define HMC_CW_HALT 8
`define HMC_SW_WARN 7
`define HMC_SW_REMOTE 9
`define HMC_SW_REACHED 10
`define HMC_SW_ILIMIT 11
`define HMC_SW_ATTAINED 12
`define HMC_SW_HERR 13
`define HMC_SW_TORQUE 15
`define HMC_HALT_RAMP 16'h0001
`define HMC_HALT_QUICK 16'h0002
`endif

// File: rtl/hmc_pkg.sv
package hmc_pkg;
  typedef struct packed {
    logic torque_limit_reached;
    logic internal_limit;
    logic warning;
    logic stop_input;
    logic excited;
    logic op_enabled;
    logic factory_default;
    logic init_done;
  } hmc_drive_st_t;
  typedef struct packed {
    logic run;
    logic decel;
    logic quick;
    logic preset;
  } hmc_motion_t;
  typedef enum logic [3:0] {
    HMC_IDLE = 4'h1,
    HMC_RUN = 4'h2,
    HMC_STOP = 4'h4,
    HMC_DONE = 4'h8
  } hmc_state_t;
endpackage

// File: rtl/hmc_param_sel.sv
`timescale 1ns/1ps
module hmc_param_sel (
  input wire logic homing_mode_i,
  input wire logic factory_default_i,
  input wire logic [31:0] drive_offset_i,
  input wire logic [31:0] sensor_offset_i,
  output logic [31:0] offset_o
);
  always_comb begin
    if (homing_mode_i) begin
      offset_o = drive_offset_i;
    end else if (factory_default_i) begin
      offset_o = sensor_offset_i;
    end else begin
      offset_o = drive_offset_i;
    end
  end
endmodule

// File: rtl/hmc_top.sv
`timescale 1ns/1ps
`include "hmc_cfg.svh"
module hmc_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cw_wr_i,
  input wire logic [15:0] cw_addr_i,
  input wire logic [15:0] cw_data_i,
  input wire logic homing_mode_i,
  input wire hmc_pkg::hmc_drive_st_t drive_st_i,
  input wire logic [15:0] halt_option_i,
  input wire logic [31:0] drive_home_offset_i,
  input wire logic [31:0] sensor_home_offset_i,
  input wire logic home_found_i,
  input wire logic home_fail_i,
  input wire logic motor_stopped_i,
  output logic [15:0] control_word_o,
  output logic [15:0] status_word_o,
  output hmc_pkg::hmc_motion_t motion_o,
  output logic [31:0] preset_value_o
);
  import hmc_pkg::*;

  hmc_drive_st_t st_s1_r, st_s2_r;
  logic found_s1_r, found_s2_r, fail_s1_r, fail_s2_r;
  logic stopped_s1_r, stopped_s2_r;
  logic [15:0] cw_r, cw_nxt;
  logic prev_start_r, prev_start_nxt;
  hmc_state_t state_r, state_nxt;
  logic attained_r, attained_nxt;
  logic herr_r, herr_nxt;
  logic reached_r, reached_nxt;
  logic quick_r, quick_nxt;
  logic preset_r, preset_nxt;
  logic [31:0] preset_val_r, preset_val_nxt;
  logic [15:0] sw_r, sw_nxt;
  logic [31:0] offset_sel;
  logic halt, start_edge, start_ok, cw_hit;

  // pins from the drive side are asynchronous to the fieldbus logic
  always_ff @(posedge ref_clk_i) begin
    st_s1_r <= drive_st_i;
    st_s2_r <= st_s1_r;
    found_s1_r <= home_found_i;
    found_s2_r <= found_s1_r;
    fail_s1_r <= home_fail_i;
    fail_s2_r <= fail_s1_r;
    stopped_s1_r <= motor_stopped_i;
    stopped_s2_r <= stopped_s1_r;
  end

  hmc_param_sel u_sel (
    .homing_mode_i(homing_mode_i),
    .factory_default_i(st_s2_r.factory_default),
    .drive_offset_i(drive_home_offset_i),
    .sensor_offset_i(sensor_home_offset_i),
    .offset_o(offset_sel)
  );

  assign cw_hit = cw_wr_i && (cw_addr_i == `HMC_CTRL_ADDR);
  assign halt = cw_r[`HMC_CW_HALT];
  // edge against the value of the previous update only
  assign start_edge = cw_hit && cw_data_i[`HMC_CW_START] &&
                      !prev_start_r;
  assign start_ok = start_edge && homing_mode_i && (state_r == HMC_IDLE)
                    && !halt && !st_s2_r.stop_input
                    && st_s2_r.op_enabled && st_s2_r.excited;

  always_comb begin
    cw_nxt = cw_r;
    prev_start_nxt = prev_start_r;
    if (cw_hit) begin
      cw_nxt = cw_data_i;
      prev_start_nxt = cw_data_i[`HMC_CW_START];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cw_r <= 16'h0000;
      prev_start_r <= 1'b0;
    end else begin
      cw_r <= cw_nxt;
      prev_start_r <= prev_start_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    attained_nxt = attained_r;
    herr_nxt = herr_r;
    reached_nxt = reached_r;
    quick_nxt = quick_r;
    preset_nxt = 1'b0;
    preset_val_nxt = preset_val_r;
    unique case (state_r)
      HMC_IDLE: begin
        if (start_ok) begin
          state_nxt = HMC_RUN;
          attained_nxt = 1'b0;
          herr_nxt = 1'b0;
          reached_nxt = 1'b0;
        end
      end
      HMC_RUN: begin
        if (fail_s2_r) begin
          herr_nxt = 1'b1;
          reached_nxt = 1'b1;
          state_nxt = HMC_IDLE;
        end else if (found_s2_r) begin
          state_nxt = HMC_DONE;
        end else if (!cw_r[`HMC_CW_START]) begin
          state_nxt = HMC_STOP;
          quick_nxt = 1'b0;
        end else if (halt) begin
          state_nxt = HMC_STOP;
          quick_nxt = (halt_option_i == `HMC_HALT_QUICK);
        end
      end
      HMC_STOP: begin
        if (stopped_s2_r) begin
          state_nxt = HMC_IDLE;
          reached_nxt = 1'b1;
          quick_nxt = 1'b0;
        end
      end
      HMC_DONE: begin
        preset_nxt = 1'b1;
        preset_val_nxt = offset_sel;
        attained_nxt = 1'b1;
        reached_nxt = 1'b1;
        state_nxt = HMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= HMC_IDLE;
      attained_r <= 1'b0;
      herr_r <= 1'b0;
      reached_r <= 1'b1;
      quick_r <= 1'b0;
      preset_r <= 1'b0;
      preset_val_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      attained_r <= attained_nxt;
      herr_r <= herr_nxt;
      reached_r <= reached_nxt;
      quick_r <= quick_nxt;
      preset_r <= preset_nxt;
      preset_val_r <= preset_val_nxt;
    end
  end

  always_comb begin
    sw_nxt = 16'h0000;
    sw_nxt[`HMC_SW_TORQUE] = st_s2_r.torque_limit_reached;
    sw_nxt[`HMC_SW_HERR] = herr_r;
    sw_nxt[`HMC_SW_ATTAINED] = attained_r;
    sw_nxt[`HMC_SW_ILIMIT] = st_s2_r.internal_limit;
    sw_nxt[`HMC_SW_REACHED] = reached_r;
    sw_nxt[`HMC_SW_REMOTE] = st_s2_r.init_done;
    sw_nxt[`HMC_SW_WARN] = st_s2_r.warning;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sw_r <= 16'h0000;
    end else begin
      sw_r <= sw_nxt;
    end
  end

  assign control_word_o = cw_r;
  assign status_word_o = sw_r;
  assign preset_value_o = preset_val_r;
  assign motion_o.run = (state_r == HMC_RUN);
  assign motion_o.decel = (state_r == HMC_STOP);
  assign motion_o.quick = quick_r;
  assign motion_o.preset = preset_r;
endmodule

// File: bench/hmc_top_props.sv
`timescale 1ns/1ps
module hmc_top_props (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cw_wr_i,
  input wire logic [15:0] cw_addr_i,
  input wire logic [15:0] cw_data_i,
  input wire logic homing_mode_i,
  input wire hmc_pkg::hmc_drive_st_t drive_st_i,
  input wire logic [31:0] drive_home_offset_i,
  input wire logic [15:0] control_word_o,
  input wire logic [15:0] status_word_o,
  input wire hmc_pkg::hmc_motion_t motion_o,
  input wire logic [31:0] preset_value_o
);
  import hmc_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic wr, go;
  logic [2:0] hs;
  assign wr = cw_wr_i && cw_addr_i == 16'h6040;
  assign hs = {status_word_o[13:12], status_word_o[10]};
  // stop, excited, enabled must settle through the synchronisers
  assign go = wr && cw_data_i[4] && !control_word_o[4] && !cw_data_i[8] &&
    !control_word_o[8] && homing_mode_i && drive_st_i[4:2] == 3'b011;
  sequence s_quiet;
    $stable(drive_st_i)[*4];
  endsequence
  sequence s_idle;
    motion_o == 4'h0 && $past(motion_o) == 4'h0;
  endsequence
  chk_start_run:
  assert property (s_quiet ##0 s_idle ##0 go |=> motion_o.run)
    else $error("start not taken");
  chk_halt_refuse:
  assert property (wr && cw_data_i[4] && control_word_o[8] &&
    motion_o == 4'h0 |=> !motion_o.run) else $error("halted start ran");
  chk_bad_addr:
  assert property (cw_wr_i && cw_addr_i != 16'h6040 |=>
    $stable(control_word_o)) else $error("foreign write stored");
  chk_cw_store:
  assert property (wr |=> control_word_o == $past(cw_data_i))
    else $error("control word lost");
  chk_clear_decel:
  assert property (motion_o.run && wr && !cw_data_i[4] |->
    ##[1:2] motion_o.decel) else $error("no deceleration");
  chk_run_status:
  assert property ($rose(motion_o.run) |=> hs == 3'b000)
    else $error("running status wrong");
  chk_preset_val:
  assert property (motion_o.preset && homing_mode_i |->
    ##[0:1] preset_value_o == drive_home_offset_i)
    else $error("preset value wrong");
  chk_done_status:
  assert property (motion_o.preset |-> ##[1:2] hs == 3'b011)
    else $error("done status wrong");
  chk_status_map:
  assert property (s_quiet |-> {status_word_o[15], status_word_o[11],
    status_word_o[9], status_word_o[7]} == {drive_st_i[7:6],
    drive_st_i[0], drive_st_i[5]}) else $error("status bits wrong");
endmodule
bind hmc_top hmc_top_props u_props (.*);

// File: bench/hmc_master.sv
`timescale 1ns/1ps
module hmc_master (
  input wire logic clk_i,
  output logic wr_o,
  output logic [15:0] addr_o,
  output logic [15:0] data_o
);
  initial {wr_o, addr_o, data_o} = '0;
  // released data flips so stale values never look valid
  task put(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    data_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    data_o <= ~d;
  endtask
endmodule

// File: bench/homing_mode_control_bench.sv
`timescale 1ns/1ps
module homing_mode_control_bench;
  import hmc_pkg::*;
  hmc_drive_st_t ds;
  hmc_motion_t mo;
  logic [31:0] doff, soff, pv;
  logic [15:0] a, d, cw, sw, hopt;
  logic clk = 0, rst = 1, wr, hm = 1, fnd = 0, fl = 0, stp = 0;
  int seed = 49052, fails = 0, num_checks = 0;
  hmc_master m (.clk_i(clk), .wr_o(wr), .addr_o(a), .data_o(d));
  hmc_top dut (.ref_clk_i(clk), .rst_i(rst), .cw_wr_i(wr), .cw_addr_i(a),
    .cw_data_i(d), .homing_mode_i(hm), .drive_st_i(ds),
    .halt_option_i(hopt), .drive_home_offset_i(doff),
    .sensor_home_offset_i(soff), .home_found_i(fnd), .home_fail_i(fl),
    .motor_stopped_i(stp), .control_word_o(cw), .status_word_o(sw),
    .motion_o(mo), .preset_value_o(pv));
  initial forever #2.5 clk = ~clk;
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  function logic [15:0] sx(input logic [2:0] h);
    sx = {ds.torque_limit_reached, 1'b0, h[2:1], ds.internal_limit, h[0],
      ds.init_done, 1'b0, ds.warning, 7'h00};
  endfunction
  task print_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    tick(4000);
    fails++;
    print_verdict;
  end
  initial begin
    ds <= 8'($random(seed)) & 8'hef | 8'h0d;
    doff <= $random(seed);
    soff <= $random(seed);
    hopt <= 16'($random(seed));
    tick(3);
    rst <= 1'b0;
    tick(6);
    chk(sw, sx(3'b001));
    for (int j = 0; j < 2; j++) begin
      doff <= $random(seed);
      m.put(16'h6040, 16'h0010);
      tick(2);
      chk(mo.run, 1'b1);
      chk(sw, sx(3'b000));
      fnd <= 1'b1;
      for (int i = 0; i < 9 && mo.preset !== 1'b1; i++) tick(1);
      chk(mo.preset, 1'b1);
      tick(2);
      chk(pv, doff);
      chk(sw, sx(3'b011));
      fnd <= 1'b0;
      m.put(16'h6040, 16'h0000);
      tick(3);
      $display("home run %0d done", j);
    end
    m.put(16'h6040, 16'h0010);
    tick(2);
    m.put(16'h6040, 16'h0000);
    tick(2);
    chk(mo.decel, 1'b1);
    stp <= 1'b1;
    tick(6);
    chk(sw, sx(3'b001));
    stp <= 1'b0;
    tick(4);
    $display("abort test done");
    // halt during a run with the quick-stop option selected
    hopt <= 16'h0002;
    m.put(16'h6040, 16'h0010);
    tick(2);
    m.put(16'h6040, 16'h0110);
    tick(2);
    chk(mo.decel, 1'b1);
    chk(mo.quick, 1'b1);
    stp <= 1'b1;
    tick(6);
    stp <= 1'b0;
    m.put(16'h6040, 16'h0000);
    tick(4);
    $display("halt test done");
    // failed search reports homing error with target reached
    m.put(16'h6040, 16'h0010);
    tick(2);
    chk(mo.run, 1'b1);
    fl <= 1'b1;
    tick(6);
    chk(mo.run, 1'b0);
    chk(sw, sx(3'b101));
    fl <= 1'b0;
    m.put(16'h6040, 16'h0000);
    tick(3);
    $display("fail test done");
    for (int k = 0; k < 5; k++) begin
      ds.stop_input <= k == 1;
      ds.op_enabled <= k != 2;
      ds.excited <= k != 3;
      hm <= k != 4;
      m.put(16'h6040, {7'h00, k == 0, 8'h00});
      tick(3);
      m.put(16'h6040, {7'h00, k == 0, 8'h10});
      tick(2);
      chk(mo.run, 1'b0);
    end
    $display("refusal test done");
    m.put(16'h6040, 16'h0000);
    m.put({1'b1, 15'($random(seed))}, 16'h0010);
    tick(2);
    chk(cw, 16'h0000);
    $display("address test done");
    print_verdict;
  end
endmodule
